// ### logic/tpu_top.v
// trigger processing unit: sources, routing matrix, outputs, acceptance, apb slave
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "tpu_consts.vh"
module tpu_top (
  // clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // trigger and encoder pins
  input wire [3:0] trig_in,
  input wire [3:0] ref_in,
  input wire enc_a,
  input wire enc_b,
  // axis one position, same clock
  input wire [31:0] pos_count,
  // trigger port outputs
  output wire [3:0] trig_out,
  output reg [3:0] trig_out_en,
  output reg [3:0] term_en,
  // packet side
  output reg [3:0] axis_trig,
  output reg packet_strobe,
  output reg [3:0] axis_valid,
  output reg [31:0] accept_count,
  output reg lost_trig
);
  // ==========================================================
  // configuration registers
  reg [31:0] port_cfg;
  reg [31:0] route_axis;
  reg [31:0] route_out;
  reg [31:0] dly01;
  reg [31:0] dly23;
  reg [31:0] tmr_period;
  reg [31:0] min_space;
  reg [31:0] ic_start;
  reg [31:0] ic_int;
  reg [31:0] ic_hys;
  reg [31:0] ic_ctl;
  reg [31:0] pc_load;
  reg [3:0] sw_ev;
  reg clr_lost;
  reg clr_cnt;
  reg pc_reload;
  wire wr_en = psel & penable & pwrite & pready;
  wire setup = psel & ~penable;
  wire [3:0] mode = port_cfg[`TPU_F_MODE +: 4];
  wire [3:0] bypass = port_cfg[`TPU_F_BYP +: 4];
  wire [3:0] edge_fall = port_cfg[`TPU_F_EDGE +: 4];
  wire [3:0] master = route_axis[`TPU_F_MASTER +: 4];
  wire [15:0] delay_cfg [0:3];
  assign delay_cfg[0] = dly01[15:0];
  assign delay_cfg[1] = dly01[`TPU_F_DLY_HI +: 16];
  assign delay_cfg[2] = dly23[15:0];
  assign delay_cfg[3] = dly23[`TPU_F_DLY_HI +: 16];

  // ==========================================================
  // input synchronisers; stage one feeds stage two only
  reg [3:0] tin_s1, tin_s2, tin_s3;
  reg [3:0] ref_s1, ref_s2, ref_s3;
  reg [1:0] ab_s1, ab_s2;
  reg gref_prev;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tin_s1 <= 4'h0; tin_s2 <= 4'h0; tin_s3 <= 4'h0;
      ref_s1 <= 4'h0; ref_s2 <= 4'h0; ref_s3 <= 4'h0;
      ab_s1 <= 2'h0; ab_s2 <= 2'h0; gref_prev <= 1'b0;
    end else if (ce) begin
      tin_s1 <= trig_in; tin_s2 <= tin_s1; tin_s3 <= tin_s2;
      ref_s1 <= ref_in; ref_s2 <= ref_s1; ref_s3 <= ref_s2;
      ab_s1 <= {enc_b, enc_a}; ab_s2 <= ab_s1;
      gref_prev <= ref_s2[0] & ab_s2[0] & ab_s2[1];
    end
  end

  // reference edges, rising or falling per axis
  wire [3:0] ref_ev = (~edge_fall & ref_s2 & ~ref_s3) | (edge_fall & ~ref_s2 & ref_s3);
  wire gref_now = ref_s2[0] & ab_s2[0] & ab_s2[1];
  wire gref_ev = edge_fall[0] ? (~gref_now & gref_prev) : (gref_now & ~gref_prev);

  // ==========================================================
  // per-input delay lines; logical-mode inputs raise no trigger
  reg [3:0] in_ev;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_dly
      reg [15:0] dcnt;
      reg pend;
      wire rise = tin_s2[gi] & ~tin_s3[gi] & ~mode[gi];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dcnt <= 16'h0000; pend <= 1'b0; in_ev[gi] <= 1'b0;
        end else if (ce) begin
          in_ev[gi] <= 1'b0;
          if (rise && delay_cfg[gi] == 16'h0000) begin
            in_ev[gi] <= 1'b1;
          end else if (rise && !pend) begin
            dcnt <= delay_cfg[gi];
            pend <= 1'b1;
          end else if (pend) begin
            dcnt <= dcnt - 16'h0001;
            if (dcnt == 16'h0001) begin
              pend <= 1'b0;
              in_ev[gi] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // periodic timer source; period zero disables it
  reg [31:0] tmr_cnt;
  reg tmr_ev;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_cnt <= `TPU_RST_ZERO; tmr_ev <= 1'b0;
    end else if (ce) begin
      tmr_ev <= 1'b0;
      if (tmr_period == `TPU_RST_ZERO || tmr_cnt >= tmr_period - 32'h0000_0001) begin
        tmr_cnt <= `TPU_RST_ZERO;
        tmr_ev <= (tmr_period != `TPU_RST_ZERO);
      end else begin
        tmr_cnt <= tmr_cnt + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // interval counter: assumes axis one moves at most one step per cycle
  reg [31:0] ic_last;
  reg ic_started;
  reg ic_armed;
  reg ic_ev;
  wire ic_en = ic_ctl[`TPU_IC_EN];
  wire ic_per = ic_ctl[`TPU_IC_PER];
  wire at_last = (pos_count == ic_last) & ic_armed;
  wire at_next = ic_per & ic_started & (ic_int != `TPU_RST_ZERO) &
                 ((pos_count == ic_last + ic_int) | (pos_count == ic_last - ic_int));
  wire far = ($signed(pos_count - ic_last) >= $signed(ic_hys)) |
             ($signed(ic_last - pos_count) >= $signed(ic_hys));
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ic_last <= `TPU_RST_ZERO; ic_started <= 1'b0; ic_armed <= 1'b1; ic_ev <= 1'b0;
    end else if (ce) begin
      ic_ev <= 1'b0;
      if (!ic_en) begin
        ic_started <= 1'b0;
        ic_armed <= 1'b1;
      end else if (!ic_started) begin
        if (pos_count == ic_start) begin
          ic_started <= 1'b1;
          ic_last <= ic_start;
          ic_armed <= 1'b0;
          ic_ev <= 1'b1;
        end
      end else if (at_next || at_last) begin
        ic_last <= pos_count;
        ic_armed <= 1'b0;
        ic_ev <= 1'b1;
      end else if (far) begin
        ic_armed <= 1'b1;
      end
    end
  end

  // ==========================================================
  // source vectors and routing; illegal routes select nothing
  function pick;
    input [3:0] code;
    input [15:0] vec;
    input [15:0] allow;
    begin
      pick = vec[code] & allow[code];
    end
  endfunction

  wire [15:0] base_vec = {2'b00, tmr_ev, sw_ev, 1'b0, ic_ev, gref_ev, ref_ev[0], in_ev, 1'b0};
  reg pc_gate;
  reg [31:0] pc_remain;
  wire pc_trig = pick(route_out[`TPU_F_PCT +: 4], base_vec, `TPU_ALLOW_PCT);
  wire pc_start = pick(route_out[`TPU_F_PCS +: 4], base_vec, `TPU_ALLOW_PCS);
  wire pc_ev = pc_trig & pc_gate;
  wire [15:0] full_vec = base_vec | ({15'h0000, pc_ev} << `TPU_SRC_PC);

  // per-axis events, own reference pulse in the ref slot
  wire [3:0] ax_ev;
  wire [3:0] ax_ref;
  wire [3:0] out_ev;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_route
      wire [3:0] sel = route_axis[gi*4 +: 4];
      wire [15:0] own = (full_vec & ~(16'h0001 << `TPU_SRC_REF)) |
                        ({15'h0000, ref_ev[gi]} << `TPU_SRC_REF);
      assign ax_ev[gi] = pick(sel, own, `TPU_ALLOW_AXIS);
      assign ax_ref[gi] = (sel == `TPU_SRC_REF);
      assign out_ev[gi] = pick(route_out[gi*4 +: 4], full_vec, `TPU_ALLOW_OUT);
    end
  endgenerate

  // ==========================================================
  // pulse counter gate; reload while open extends the budget
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_gate <= 1'b0; pc_remain <= `TPU_RST_ZERO;
    end else if (ce) begin
      if (pc_gate && pc_reload) begin
        pc_remain <= pc_remain + pc_load - {31'h0000_0000, pc_ev};
      end else if (pc_gate && pc_ev) begin
        pc_remain <= pc_remain - 32'h0000_0001;
        if (pc_remain == 32'h0000_0001) begin
          pc_gate <= 1'b0;
        end
      end else if (!pc_gate && pc_start && pc_load != `TPU_RST_ZERO) begin
        pc_gate <= 1'b1;
        pc_remain <= pc_load;
      end
    end
  end

  // ==========================================================
  // master event; a reference master waits for every ref axis
  reg [3:0] seen;
  wire [3:0] seen_now = seen | ax_ev;
  wire m_is_ref = (master == `TPU_SRC_REF);
  wire m_ref_ev = (|ax_ref) & ((seen_now & ax_ref) == ax_ref) & (|(ax_ev & ax_ref));
  wire m_raw = m_is_ref ? m_ref_ev : pick(master, full_vec, `TPU_ALLOW_AXIS);
  reg [31:0] space_cnt;
  wire m_ok = m_raw & (space_cnt >= min_space);
  wire [3:0] by_master;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_mst
      assign by_master[gi] = (route_axis[gi*4 +: 4] == master);
    end
  endgenerate

  // acceptance, packet strobe, validity, counters
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      space_cnt <= `TPU_SAT; seen <= 4'h0; packet_strobe <= 1'b0;
      axis_valid <= 4'h0; axis_trig <= 4'h0; accept_count <= `TPU_RST_ZERO;
      lost_trig <= 1'b0;
    end else if (ce) begin
      axis_trig <= ax_ev;
      packet_strobe <= m_ok;
      if (m_ok) begin
        space_cnt <= `TPU_RST_ZERO;
        axis_valid <= by_master | seen_now;
        seen <= 4'h0;
      end else begin
        seen <= seen_now;
        if (space_cnt != `TPU_SAT) begin
          space_cnt <= space_cnt + 32'h0000_0001;
        end
      end
      if (m_ok) begin
        accept_count <= accept_count + 32'h0000_0001;
      end else if (clr_cnt) begin
        accept_count <= `TPU_RST_ZERO;
      end
      // set beats a clear in the same cycle
      if (m_raw && !m_ok) begin
        lost_trig <= 1'b1;
      end else if (clr_lost) begin
        lost_trig <= 1'b0;
      end
    end
  end

  // ==========================================================
  // output pulse stretchers and port muxing
  reg [3:0] out_q;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_out
      reg [7:0] pcnt;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pcnt <= 8'h00; out_q[gi] <= 1'b0;
        end else if (ce) begin
          if (mode[gi]) begin
            pcnt <= 8'h00;
            out_q[gi] <= port_cfg[`TPU_F_LVL + gi];
          end else if (out_ev[gi] && pcnt == 8'h00) begin
            pcnt <= `TPU_PULSE_LOAD;
            out_q[gi] <= 1'b1;
          end else if (pcnt != 8'h00) begin
            pcnt <= pcnt - 8'h01;
            out_q[gi] <= (pcnt != 8'h01);
          end else begin
            out_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // bypass takes the raw pin so no clock jitter is added
  assign trig_out = (bypass & ~mode & trig_in) | (~(bypass & ~mode) & out_q);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_out_en <= 4'h0; term_en <= 4'h0;
    end else if (ce) begin
      trig_out_en <= port_cfg[`TPU_F_OEN +: 4];
      term_en <= port_cfg[`TPU_F_TERM +: 4];
    end
  end

  // ==========================================================
  // apb slave: no wait states, errors on unmapped addresses
  reg [31:0] rd_mux;
  reg hit;
  always @* begin
    hit = 1'b1;
    rd_mux = `TPU_RST_ZERO;
    case (paddr)
      `TPU_REG_CMD: rd_mux = `TPU_RST_ZERO;
      `TPU_REG_PORT: rd_mux = port_cfg;
      `TPU_REG_RAXIS: rd_mux = route_axis;
      `TPU_REG_ROUT: rd_mux = route_out;
      `TPU_REG_DLY01: rd_mux = dly01;
      `TPU_REG_DLY23: rd_mux = dly23;
      `TPU_REG_TIMER: rd_mux = tmr_period;
      `TPU_REG_SPACE: rd_mux = min_space;
      `TPU_REG_ICSTART: rd_mux = ic_start;
      `TPU_REG_ICINT: rd_mux = ic_int;
      `TPU_REG_ICHYS: rd_mux = ic_hys;
      `TPU_REG_ICCTL: rd_mux = ic_ctl;
      `TPU_REG_PCLOAD: rd_mux = pc_load;
      `TPU_REG_STATUS: begin
        rd_mux[`TPU_ST_LIN +: 4] = tin_s2 & mode;
        rd_mux[`TPU_ST_LOUT +: 4] = out_q;
        rd_mux[`TPU_ST_LOST] = lost_trig;
        rd_mux[`TPU_ST_GATE] = pc_gate;
      end
      `TPU_REG_COUNT: rd_mux = accept_count;
      default: hit = 1'b0;
    endcase
  end

  // answer and register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `TPU_RST_ZERO; pready <= 1'b0; pslverr <= 1'b0;
      port_cfg <= `TPU_RST_ZERO; route_axis <= `TPU_RST_ZERO;
      route_out <= `TPU_RST_ZERO; dly01 <= `TPU_RST_ZERO; dly23 <= `TPU_RST_ZERO;
      tmr_period <= `TPU_RST_ZERO; min_space <= `TPU_SPACE_RST;
      ic_start <= `TPU_RST_ZERO; ic_int <= `TPU_RST_ZERO; ic_hys <= `TPU_RST_ZERO;
      ic_ctl <= `TPU_RST_ZERO; pc_load <= `TPU_RST_ZERO;
      sw_ev <= 4'h0; clr_lost <= 1'b0; clr_cnt <= 1'b0; pc_reload <= 1'b0;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= (setup & ~pwrite) ? rd_mux : `TPU_RST_ZERO;
      sw_ev <= 4'h0;
      clr_lost <= 1'b0;
      clr_cnt <= 1'b0;
      pc_reload <= 1'b0;
      if (wr_en) begin
        case (paddr)
          `TPU_REG_CMD: begin
            sw_ev <= pwdata[`TPU_CMD_SW +: 4];
            clr_lost <= pwdata[`TPU_CMD_CLR_LOST];
            clr_cnt <= pwdata[`TPU_CMD_CLR_CNT];
          end
          `TPU_REG_PORT: port_cfg <= pwdata;
          `TPU_REG_RAXIS: route_axis <= pwdata;
          `TPU_REG_ROUT: route_out <= pwdata;
          `TPU_REG_DLY01: dly01 <= pwdata;
          `TPU_REG_DLY23: dly23 <= pwdata;
          `TPU_REG_TIMER: tmr_period <= pwdata;
          `TPU_REG_SPACE: min_space <= pwdata;
          `TPU_REG_ICSTART: ic_start <= pwdata;
          `TPU_REG_ICINT: ic_int <= pwdata;
          `TPU_REG_ICHYS: ic_hys <= pwdata;
          `TPU_REG_ICCTL: ic_ctl <= pwdata;
          `TPU_REG_PCLOAD: begin
            pc_load <= pwdata;
            pc_reload <= 1'b1;
          end
          default: pc_reload <= 1'b0;
        endcase
      end
    end
  end
endmodule // tpu_top
`default_nettype wire

// ### include/tpu_consts.vh
// constants for the trigger processing unit
`ifndef TPU_CONSTS_VH
`define TPU_CONSTS_VH
// ==========================================================
// register byte offsets
`define TPU_REG_CMD 8'h00
`define TPU_REG_PORT 8'h04
`define TPU_REG_RAXIS 8'h08
`define TPU_REG_ROUT 8'h0C
`define TPU_REG_DLY01 8'h10
`define TPU_REG_DLY23 8'h14
`define TPU_REG_TIMER 8'h18
`define TPU_REG_SPACE 8'h1C
`define TPU_REG_ICSTART 8'h20
`define TPU_REG_ICINT 8'h24
`define TPU_REG_ICHYS 8'h28
`define TPU_REG_ICCTL 8'h2C
`define TPU_REG_PCLOAD 8'h30
`define TPU_REG_STATUS 8'h34
`define TPU_REG_COUNT 8'h38
// ==========================================================
// field positions
`define TPU_CMD_CLR_LOST 0
`define TPU_CMD_CLR_CNT 1
`define TPU_CMD_SW 4
`define TPU_F_MODE 0
`define TPU_F_BYP 4
`define TPU_F_TERM 8
`define TPU_F_OEN 12
`define TPU_F_LVL 16
`define TPU_F_EDGE 20
`define TPU_F_MASTER 16
`define TPU_F_PCT 16
`define TPU_F_PCS 20
`define TPU_F_DLY_HI 16
`define TPU_IC_EN 0
`define TPU_IC_PER 1
`define TPU_ST_LIN 0
`define TPU_ST_LOUT 4
`define TPU_ST_LOST 8
`define TPU_ST_GATE 9
// ==========================================================
// source codes and allowed-source masks per sink class
`define TPU_SRC_REF 5
`define TPU_SRC_PC 8
`define TPU_ALLOW_AXIS 16'h3FFE
`define TPU_ALLOW_OUT 16'h3FDE
`define TPU_ALLOW_PCT 16'h20FE
`define TPU_ALLOW_PCS 16'h1EFE
// ==========================================================
// reset values and timing
`define TPU_RST_ZERO 32'h0000_0000
`define TPU_SPACE_RST 32'h0000_0064
`define TPU_SAT 32'hFFFF_FFFF
`define TPU_CLK_MHZ 100
`define TPU_PULSE_US 2
`define TPU_PULSE_CYC (`TPU_PULSE_US * `TPU_CLK_MHZ)
// stretcher load: equals the pulse length so the high phase spans the full 2 us
`define TPU_PULSE_LOAD 8'hC8
`endif

// ### tb/tpu_top_props.sv
// checker for the trigger processing unit top ports
`timescale 1ns/100ps
`default_nettype none
module tpu_top_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // pins and packet side
  input wire logic [3:0] trig_in,
  input wire logic [3:0] trig_out,
  input wire logic [3:0] trig_out_en,
  input wire logic [3:0] term_en,
  input wire logic packet_strobe,
  input wire logic [3:0] axis_trig,
  input wire logic [3:0] axis_valid,
  input wire logic [31:0] accept_count,
  input wire logic lost_trig
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic clr_lost;
  logic clr_cnt;
  logic [31:0] port_s;
  logic [31:0] raxis_s;
  logic [31:0] space_s;
  logic [31:0] gap;
  logic [31:0] wcnt;
  logic [3:0] mm;
  integer i;
  // write strobes as the slave sees them at the completing edge
  assign wr = psel && penable && pwrite && pready;
  assign clr_lost = wr && (paddr == 8'h00) && pwdata[0];
  assign clr_cnt = wr && (paddr == 8'h00) && pwdata[1];
  // shadows of the configuration that the assertions depend on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_s <= 32'h0000_0000;
      raxis_s <= 32'h0000_0000;
      space_s <= 32'h0000_0064;
    end else if (wr) begin
      if (paddr == 8'h04) port_s <= pwdata;
      if (paddr == 8'h08) raxis_s <= pwdata;
      if (paddr == 8'h1C) space_s <= pwdata;
    end
  end
  // distance since the last accepted trigger, saturating so idle time never wraps
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) gap <= 32'hFFFF_FFFF;
    else if (packet_strobe) gap <= 32'h0000_0001;
    else if (gap != 32'hFFFF_FFFF) gap <= gap + 32'h0000_0001;
  end
  // length of the current high phase on output 0
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) wcnt <= 32'h0000_0000;
    else if (trig_out[0]) wcnt <= wcnt + 32'h0000_0001;
    else wcnt <= 32'h0000_0000;
  end
  // axes driven by the master source
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      mm[i] = (raxis_s[4*i+:4] == raxis_s[19:16]) && (raxis_s[19:16] != 4'h0) &&
              (raxis_s[19:16] < 4'hE);
    end
  end
  // the command register acts one cycle after the bus write, hence the past clear
  lost_sticky_a: assert property (lost_trig && !$past(clr_lost) |=> lost_trig)
    else $error("lost flag dropped without clear");
  count_step_a: assert property ($changed(accept_count) && !$past(clr_cnt, 2) |->
    accept_count == $past(accept_count) + 32'h0000_0001)
    else $error("accept count moved by other than one");
  count_cause_a: assert property ($changed(accept_count) && !$past(clr_cnt, 2) |->
    packet_strobe || $past(packet_strobe))
    else $error("accept count moved without accepted trigger");
  min_spacing_a: assert property (packet_strobe |-> gap >= space_s)
    else $error("accepted triggers closer than spacing");
  pulse_width_a: assert property ($fell(trig_out[0]) && !port_s[0] && !port_s[4] |->
    wcnt == 32'd200)
    else $error("output pulse not 200 cycles");
  bypass_pass_a: assert property (!port_s[0] && port_s[4] |-> trig_out[0] == trig_in[0])
    else $error("bypass output differs from input");
  out_enable_a: assert property (wr && paddr == 8'h04 |=> ##1
    trig_out_en == $past(pwdata[15:12], 2))
    else $error("output enable not taken from port setting");
  term_follow_a: assert property (wr && paddr == 8'h04 |=> ##1
    term_en == $past(pwdata[11:8], 2))
    else $error("termination not taken from port setting");
  master_valid_a: assert property (packet_strobe |-> ##[0:1] ((axis_valid & mm) == mm))
    else $error("master axis not valid in packet");
  // axes on a non-reference master source see their own event with every packet
  master_trig_a: assert property (packet_strobe && raxis_s[19:16] != 4'h5 |->
    ((axis_trig & mm) == mm))
    else $error("master axis missed its trigger");
endmodule // tpu_top_props
bind tpu_top tpu_top_props i_tpu_top_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .trig_in(trig_in), .trig_out(trig_out), .trig_out_en(trig_out_en), .term_en(term_en),
  .packet_strobe(packet_strobe), .axis_trig(axis_trig), .axis_valid(axis_valid),
  .accept_count(accept_count),
  .lost_trig(lost_trig));
`default_nettype wire

// ### tb/tpu_trig_src.sv
// partner model: external trigger source and chained trigger receiver
`timescale 1ns/100ps
`default_nettype none
module tpu_trig_src (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests from the bench
  input wire logic [3:0] fire,
  input wire logic [3:0] lvl,
  // pins
  output logic [3:0] trig_in,
  input wire logic [3:0] trig_out,
  // receiver view of output 0
  output logic [31:0] last_width,
  output logic [31:0] rises
);
  logic [4:0] hold [0:3];
  logic [31:0] run;
  logic prev;
  integer i;
  integer j;
  // fixed 20-cycle pulses; requests while busy are dropped, keeping the rate low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 4; i = i + 1) hold[i] <= 5'h00;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (hold[i] != 5'h00) hold[i] <= hold[i] - 5'h01;
        else if (fire[i]) hold[i] <= 5'h14;
      end
    end
  end
  // pin level is the held level or the pulse
  always @* begin
    for (j = 0; j < 4; j = j + 1) trig_in[j] = lvl[j] | (hold[j] != 5'h00);
  end
  // receiver: width of each completed pulse and number of rising edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 32'h0000_0000;
      last_width <= 32'h0000_0000;
      rises <= 32'h0000_0000;
      prev <= 1'b0;
    end else begin
      prev <= trig_out[0];
      if (trig_out[0]) run <= run + 32'h0000_0001;
      else run <= 32'h0000_0000;
      if (prev && !trig_out[0]) last_width <= run;
      if (!prev && trig_out[0]) rises <= rises + 32'h0000_0001;
    end
  end
endmodule // tpu_trig_src
`default_nettype wire

// ### tb/tpu_top_tb_top.sv
// testbench top for the trigger processing unit
`timescale 1ns/100ps
`default_nettype none
`include "tpu_consts.vh"
module tpu_top_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, packet_strobe, lost_trig, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, accept_count, last_width, rises, rd, r0;
  logic [3:0] trig_in, ref_in, trig_out, trig_out_en, term_en, axis_trig, axis_valid, fire, lvl;
  integer mismatches, total_checks, k;
  // ==========================================================
  // design, partner and clock
  tpu_top i_tpu_top (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .ref_in(ref_in), .enc_a(1'b0),
    .enc_b(1'b0), .pos_count(32'h0000_0000), .trig_out(trig_out), .trig_out_en(trig_out_en),
    .term_en(term_en), .axis_trig(axis_trig), .packet_strobe(packet_strobe),
    .axis_valid(axis_valid), .accept_count(accept_count), .lost_trig(lost_trig));
  tpu_trig_src i_tpu_trig_src (.pclk(pclk), .presetn(presetn), .fire(fire), .lvl(lvl),
    .trig_in(trig_in), .trig_out(trig_out), .last_width(last_width), .rises(rises));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ==========================================================
  // verdict, comparison and bus tasks
  task end_of_test;
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n = n + 1;
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  endtask
  task pulse(input logic [3:0] m);
    @(posedge pclk);
    fire <= m;
    @(posedge pclk);
    fire <= 4'h0;
  endtask
  // bounded wait for the next accepted master trigger
  task wait_pkt;
    integer n;
    n = 0;
    @(posedge pclk);
    while (packet_strobe !== 1'b1 && n < 300) begin
      n = n + 1;
      @(posedge pclk);
    end
    if (n == 300) begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    mismatches = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fire = 4'h0;
    lvl = 4'h0;
    ref_in = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(`TPU_REG_PORT, 1'b0, 32'h0000_0000);
    check(rd, `TPU_RST_ZERO);
    xfer(`TPU_REG_SPACE, 1'b0, 32'h0000_0000);
    check(rd, `TPU_SPACE_RST);
    xfer(8'h3C, 1'b0, 32'h0000_0000);
    check({31'h0000_0000, er}, 32'h0000_0001);
    // input 0 drives axis 0, the master and output 0
    xfer(`TPU_REG_SPACE, 1'b1, 32'h0000_0032);
    xfer(`TPU_REG_RAXIS, 1'b1, 32'h0001_0001);
    xfer(`TPU_REG_ROUT, 1'b1, 32'h0000_0001);
    pulse(4'h1);
    wait_pkt;
    check({31'h0000_0000, axis_valid[0]}, 32'h0000_0001);
    xfer(`TPU_REG_COUNT, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    // second trigger well inside the spacing is dropped
    repeat (25) @(posedge pclk);
    pulse(4'h1);
    repeat (30) @(posedge pclk);
    xfer(`TPU_REG_STATUS, 1'b0, 32'h0000_0000);
    check(rd & 32'h0000_0100, 32'h0000_0100);
    xfer(`TPU_REG_COUNT, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    repeat (200) @(posedge pclk);
    check(last_width, `TPU_PULSE_CYC);
    xfer(`TPU_REG_CMD, 1'b1, 32'h0000_0001);
    xfer(`TPU_REG_STATUS, 1'b0, 32'h0000_0000);
    check(rd & 32'h0000_0100, 32'h0000_0000);
    xfer(`TPU_REG_CMD, 1'b1, 32'h0000_0002);
    // every software channel as master, fired by command
    for (k = 0; k < 4; k = k + 1) begin
      xfer(`TPU_REG_RAXIS, 1'b1, ((32'h0000_0009 + k) << 16) | (32'h0000_0009 + k));
      xfer(`TPU_REG_CMD, 1'b1, 32'h0000_0010 << k);
      wait_pkt;
      repeat (60) @(posedge pclk);
      xfer(`TPU_REG_COUNT, 1'b0, 32'h0000_0000);
      check(rd, k + 1);
    end
    // plain reference pulse may not reach an output
    r0 = rises;
    xfer(`TPU_REG_ROUT, 1'b1, 32'h0000_0005);
    ref_in <= 4'h1;
    repeat (20) @(posedge pclk);
    ref_in <= 4'h0;
    repeat (10) @(posedge pclk);
    check(rises, r0);
    // logical mode on port 0 with termination and enable
    xfer(`TPU_REG_PORT, 1'b1, 32'h0001_1101);
    lvl <= 4'h1;
    repeat (5) @(posedge pclk);
    xfer(`TPU_REG_STATUS, 1'b0, 32'h0000_0000);
    check(rd & 32'h0000_0011, 32'h0000_0011);
    check({28'h000_0000, trig_out_en}, 32'h0000_0001);
    check({28'h000_0000, term_en}, 32'h0000_0001);
    // bypass follows the raw pin
    xfer(`TPU_REG_PORT, 1'b1, 32'h0000_0010);
    repeat (2) @(posedge pclk);
    check({31'h0000_0000, trig_out[0]}, 32'h0000_0001);
    lvl <= 4'h0;
    repeat (2) @(posedge pclk);
    check({31'h0000_0000, trig_out[0]}, 32'h0000_0000);
    end_of_test;
  end
endmodule // tpu_top_tb_top
`default_nettype wire
